// *** logic/frame_acquisition_sequencer.v ***
// Implementation choices: the register offsets and the plain strobed port.
`timescale 1ns/10ps
`include "acq_seq_map.vh"
`default_nettype none
module frame_acquisition_sequencer (
  input wire clock_i,
  input wire rst_i,
  input wire [3:0] addr_i,
  input wire [31:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [31:0] rdata_o,
  input wire line1_i,
  input wire scheme_startup_i,
  input wire startup_load_i,
  output reg frame_active_o,
  output reg frame_start_o,
  output wire [2:0] acq_status_o
);
  // ----------------------------------------
  // States
  // ----------------------------------------
  // Idle: no start command in effect
  // Wait arm: started, arming event still due
  // Wait frame: the only state that takes frame triggers
  // Frame: exposure and readout running
  // Stopping: frame running, stop already seen
  // Status port shows the code directly, so
  // software sees these values unchanged;
  // keep the codes stable if states are added
  localparam ST_IDLE = 3'h0;
  localparam ST_WAIT_ARM = 3'h1;
  localparam ST_WAIT_FRAME = 3'h2;
  localparam ST_FRAME = 3'h3;
  localparam ST_STOPPING = 3'h4;

  // Sequencer state and settings
  // Settings are plain flops written from the port;
  // none of them is double-buffered, so a change
  // lands on the next edge even mid-frame
  reg [2:0] state_q;
  reg [2:0] state_d;
  reg control_scheme_select_q;
  reg cont_q;
  reg trig_sel_q;
  reg arm_ext_q;
  reg arm_src_q;
  reg frm_ext_q;
  reg frm_src_q;
  reg [15:0] fcount_q;
  reg [31:0] period_q;
  reg [31:0] framelen_q;
  // Frames taken since arming, compared with the budget
  // Cleared on start and on an arming event taken in wait-arm
  reg [15:0] taken_q;
  reg [15:0] taken_d;
  reg [31:0] gen_cnt_q;
  reg [31:0] len_cnt_q;
  reg [31:0] len_cnt_d;
  reg line1_q;
  reg frame_start_d;

  // ----------------------------------------
  // Register writes and command decode
  // ----------------------------------------
  wire wr_ctrl = wr_i && (addr_i == `ACQ_REG_CTRL);
  wire wr_cmd = wr_i && (addr_i == `ACQ_REG_CMD);
  wire cmd_start = wr_cmd && wdata_i[`CMD_START_BIT];
  wire cmd_stop = wr_cmd && wdata_i[`CMD_STOP_BIT];
  wire cmd_swtrig = wr_cmd && wdata_i[`CMD_SWTRIG_BIT];
  wire line1_edge = line1_i && !line1_q;

  // Configuration; the startup strobe reloads the saved scheme
  // Startup load wins over a control write in the same
  // cycle: the saved scheme is what software expects
  // to find after a power-up sequence
  // Line 1 history is kept here for edge detection;
  // it resets low, the idle level of the line, so
  // no false edge follows reset
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      control_scheme_select_q <= 1'b0;
      cont_q <= 1'b0;
      trig_sel_q <= 1'b0;
      arm_ext_q <= 1'b0;
      arm_src_q <= 1'b0;
      frm_ext_q <= 1'b0;
      frm_src_q <= 1'b0;
      fcount_q <= `FCOUNT_RESET;
      period_q <= `PERIOD_RESET;
      framelen_q <= `FRAMELEN_RESET;
      line1_q <= 1'b0;
    end else begin
      line1_q <= line1_i;
      if (startup_load_i) begin
        control_scheme_select_q <= scheme_startup_i;
      end else if (wr_ctrl) begin
        control_scheme_select_q <= wdata_i[`CTRL_SCHEME_BIT];
        cont_q <= wdata_i[`CTRL_CONT_BIT];
      end
      if (wr_i && addr_i == `ACQ_REG_TRIG) begin
        trig_sel_q <= wdata_i[`TRIG_SEL_BIT];
        // Only the selected trigger takes the shared settings
        if (!wdata_i[`TRIG_SEL_BIT]) begin
          arm_ext_q <= wdata_i[`TRIG_ARM_EXT_BIT];
          arm_src_q <= wdata_i[`TRIG_ARM_SRC_BIT];
        end else begin
          frm_ext_q <= wdata_i[`TRIG_FRM_EXT_BIT];
          frm_src_q <= wdata_i[`TRIG_FRM_SRC_BIT];
        end
      end
      if (wr_i && addr_i == `ACQ_REG_FCOUNT) begin
        fcount_q <= wdata_i[15:0];
      end
      if (wr_i && addr_i == `ACQ_REG_PERIOD) begin
        period_q <= wdata_i;
      end
      if (wr_i && addr_i == `ACQ_REG_FRAMELEN) begin
        framelen_q <= wdata_i;
      end
    end
  end

  // ----------------------------------------
  // Trigger sources
  // ----------------------------------------
  // Software command goes to whichever trigger is selected
  // A selector change and a software trigger in one
  // write are not merged: the trigger follows the
  // selector as it stood before that write
  // Line 1 feeds either trigger on its rising edge;
  // both see the same edge if both pick line 1, but only the trigger that the current wait state takes acts on it
  wire sw_arm = cmd_swtrig && !trig_sel_q;
  wire sw_frm = cmd_swtrig && trig_sel_q;
  wire arm_evt = arm_src_q ? line1_edge : sw_arm;
  wire ext_frm_evt = frm_src_q ? line1_edge : sw_frm;
  // Arming stage exists only in the full scheme
  wire arm_used = control_scheme_select_q && arm_ext_q;
  wire gen_tick = (gen_cnt_q == 32'h0);
  wire frm_evt = frm_ext_q ? ext_frm_evt : gen_tick;
  wire frame_done = (state_q == ST_FRAME || state_q == ST_STOPPING) && (len_cnt_q == 32'h0);

  // Internal frame-rate generator, free running at the set period
  // A period write restarts the count, so a new rate
  // holds at once instead of after the old period
  // Ticks outside wait-frame are simply lost
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      gen_cnt_q <= 32'h0;
    end else if (wr_i && addr_i == `ACQ_REG_PERIOD) begin
      gen_cnt_q <= wdata_i - 32'h1;
    end else if (gen_tick) begin
      gen_cnt_q <= period_q - 32'h1;
    end else begin
      gen_cnt_q <= gen_cnt_q - 32'h1;
    end
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  // Next state, budget count and frame length
  // A stop in a wait state ends the run at once;
  // a stop during a frame lets the frame finish
  // Single-frame runs lapse after one frame,
  // so the start command must be given again
  // Budget uses >= so a budget lowered below the
  // frames already taken still returns to wait-arm
  // Start outside idle is ignored on purpose:
  // a second start must not clear the budget count
  always @* begin
    state_d = state_q;
    taken_d = taken_q;
    len_cnt_d = len_cnt_q;
    frame_start_d = 1'b0;
    case (state_q)
      ST_IDLE: begin
        if (cmd_start) begin
          taken_d = 16'h0;
          state_d = arm_used ? ST_WAIT_ARM : ST_WAIT_FRAME;
        end
      end
      ST_WAIT_ARM: begin
        if (cmd_stop) begin
          state_d = ST_IDLE;
        end else if (arm_evt) begin
          taken_d = 16'h0;
          state_d = ST_WAIT_FRAME;
        end
      end
      ST_WAIT_FRAME: begin
        if (cmd_stop) begin
          state_d = ST_IDLE;
        end else if (frm_evt) begin
          taken_d = taken_q + 16'h1;
          len_cnt_d = framelen_q;
          frame_start_d = 1'b1;
          state_d = ST_FRAME;
        end
      end
      ST_FRAME, ST_STOPPING: begin
        // Triggers here fall through unused
        if (cmd_stop) begin
          state_d = ST_STOPPING;
        end
        if (frame_done) begin
          if (state_q == ST_STOPPING || cmd_stop || !cont_q) begin
            state_d = ST_IDLE;
          end else if (arm_used && taken_q >= fcount_q) begin
            state_d = ST_WAIT_ARM;
          end else begin
            state_d = ST_WAIT_FRAME;
          end
        end else begin
          len_cnt_d = len_cnt_q - 32'h1;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // State and outputs; frame_start_o is one cycle
  // Busy flag is taken from the next state so that
  // it lines up with the state code on the status port
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= ST_IDLE;
      taken_q <= 16'h0;
      len_cnt_q <= 32'h0;
      frame_start_o <= 1'b0;
      frame_active_o <= 1'b0;
    end else begin
      state_q <= state_d;
      taken_q <= taken_d;
      len_cnt_q <= len_cnt_d;
      frame_start_o <= frame_start_d;
      frame_active_o <= (state_d == ST_FRAME) || (state_d == ST_STOPPING);
    end
  end

  assign acq_status_o = state_q;

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  // In compatibility scheme the frame trigger reads back in the arming slot
  // Read data stand for one cycle and are zero
  // otherwise, so a bus with wired-or read data
  // can share this port with other blocks
  // Command register reads back as zero
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 32'h0;
    end else if (rd_i) begin
      case (addr_i)
        `ACQ_REG_CTRL: rdata_o <= {30'h0, cont_q, control_scheme_select_q};
        `ACQ_REG_TRIG: rdata_o <= control_scheme_select_q ?
          {27'h0, frm_src_q, frm_ext_q, arm_src_q, arm_ext_q, trig_sel_q} :
          {27'h0, 2'h0, frm_src_q, frm_ext_q, trig_sel_q};
        `ACQ_REG_FCOUNT: rdata_o <= {16'h0, fcount_q};
        `ACQ_REG_PERIOD: rdata_o <= period_q;
        `ACQ_REG_FRAMELEN: rdata_o <= framelen_q;
        `ACQ_REG_STATUS: rdata_o <= {13'h0, taken_q, state_q};
        default: rdata_o <= 32'h0;
      endcase
    end else begin
      rdata_o <= 32'h0;
    end
  end
endmodule // frame_acquisition_sequencer
`default_nettype wire

// *** logic/acq_seq_map.vh ***
`ifndef ACQ_SEQ_MAP_VH
`define ACQ_SEQ_MAP_VH
// ----------------------------------------
// Register offsets (word index on the port)
// ----------------------------------------
`define ACQ_REG_CTRL 4'h0
`define ACQ_REG_CMD 4'h1
`define ACQ_REG_TRIG 4'h2
`define ACQ_REG_FCOUNT 4'h3
`define ACQ_REG_PERIOD 4'h4
`define ACQ_REG_FRAMELEN 4'h5
`define ACQ_REG_STATUS 4'h6
// ----------------------------------------
// Control register fields
// ----------------------------------------
`define CTRL_SCHEME_BIT 0
`define CTRL_CONT_BIT 1
`define CTRL_RESET_VAL 2'h0
// ----------------------------------------
// Command register bits (write one to issue)
// ----------------------------------------
`define CMD_START_BIT 0
`define CMD_STOP_BIT 1
`define CMD_SWTRIG_BIT 2
// ----------------------------------------
// Trigger register fields
// ----------------------------------------
`define TRIG_SEL_BIT 0
`define TRIG_ARM_EXT_BIT 1
`define TRIG_ARM_SRC_BIT 2
`define TRIG_FRM_EXT_BIT 3
`define TRIG_FRM_SRC_BIT 4
// ----------------------------------------
// Reset values of counts
// ----------------------------------------
`define FCOUNT_RESET 16'h0001
`define PERIOD_RESET 32'h00000100
`define FRAMELEN_RESET 32'h00000040
`define STATUS_WIDTH 3
`endif

// *** tb/acq_seq_chk.sv ***
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Port checker
// ----------------------------------------
module acq_seq_chk (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic frame_active_o,
  input wire logic frame_start_o,
  input wire logic [2:0] acq_status_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  // Frame start is a lone pulse taken only from wait-frame
  start_pulse_a: assert property (frame_start_o |=> !frame_start_o) else $error("start pulse too long");
  start_wait_a: assert property (frame_start_o |-> $past(acq_status_o) == 3'h2) else $error("start outside wait");
  start_frame_a: assert property (frame_start_o |-> ##[0:1] acq_status_o == 3'h3) else $error("no frame state");
  idle_quiet_a: assert property (acq_status_o == 3'h0 |-> !frame_start_o) else $error("frame while idle");
  arm_quiet_a: assert property (acq_status_o == 3'h1 |-> !frame_start_o) else $error("frame while unarmed");
  frame_busy_a: assert property (acq_status_o inside {3'h3, 3'h4} |-> frame_active_o) else $error("frame not busy");
  stop_exit_a: assert property (acq_status_o == 3'h4 |=> acq_status_o inside {3'h0, 3'h4}) else $error("bad exit");
  read_idle_a: assert property (!$past(rd_i) |-> rdata_o == 32'h0) else $error("stray read data");
  // Main scenarios reached
  cover property (frame_start_o);
  cover property (acq_status_o == 3'h1);
  cover property (acq_status_o == 3'h4);
endmodule // acq_seq_chk
bind frame_acquisition_sequencer acq_seq_chk chk (.clock_i(clock_i), .rst_i(rst_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .frame_active_o(frame_active_o), .frame_start_o(frame_start_o), .acq_status_o(acq_status_o));
`default_nettype wire

// *** tb/trig_source.sv ***
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// External trigger source on line 1
// ----------------------------------------
module trig_source (
  input wire logic clock_i,
  input wire logic fire_i,
  output logic line_o
);
  logic [1:0] cnt_q;
  // Two-cycle high pulse; the bench spaces fires so each is a fresh edge
  always @(posedge clock_i) begin
    if (fire_i) cnt_q <= 2'h2;
    else if (cnt_q != 2'h0) cnt_q <= cnt_q - 2'h1;
  end
  initial cnt_q = 2'h0;
  assign line_o = (cnt_q != 2'h0);
endmodule // trig_source
`default_nettype wire

// *** tb/frame_acquisition_sequencer_tb_top.sv ***
`timescale 1ns/10ps
`include "acq_seq_map.vh"
`default_nettype none
module frame_acquisition_sequencer_tb_top;
  logic clock_i = 0, rst_i = 1, wr_i = 0, rd_i = 0, fire = 0, scheme_startup_i = 0, startup_load_i = 0;
  logic [3:0] addr_i = 0;
  logic [31:0] wdata_i = 0;
  wire [31:0] rdata_o;
  wire line1_i, frame_active_o, frame_start_o;
  wire [2:0] acq_status_o;
  int n_fail = 0, checked = 0, cyc = 0, nfr = 0, n0, per;
  // ----------------------------------------
  // Clock, frame counter, hang guard
  // ----------------------------------------
  always #12.5 clock_i = ~clock_i;
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (frame_start_o === 1'b1) nfr <= nfr + 1;
    if (cyc == 5000) begin
      n_fail++;
      end_sim;
    end
  end
  frame_acquisition_sequencer uut (.clock_i(clock_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .line1_i(line1_i), .scheme_startup_i(scheme_startup_i),
    .startup_load_i(startup_load_i), .frame_active_o(frame_active_o), .frame_start_o(frame_start_o),
    .acq_status_o(acq_status_o));
  trig_source src (.clock_i(clock_i), .fire_i(fire), .line_o(line1_i));
  // Compatibility view puts frame pair in the arming slot
  function logic [31:0] trig_view(input logic sel, input logic ext, input logic src);
    return {29'h0, src, ext, sel};
  endfunction
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  // Gap cycle after each strobe so no strobe is set twice in one step
  task wr(input logic [3:0] a, input logic [31:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
    @(posedge clock_i);
  endtask
  task rd(input logic [3:0] a, input logic [31:0] e, input string n);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    @(negedge clock_i);
    chk(n, e, rdata_o);
    @(posedge clock_i);
  endtask
  task idle(input int k);
    repeat (k) @(posedge clock_i);
  endtask
  task pulse;
    fire <= 1'b1;
    @(posedge clock_i);
    fire <= 1'b0;
    idle(3);
  endtask
  task end_sim;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    void'($urandom(32'he910));
    idle(16);
    rst_i <= 1'b0;
    rd(`ACQ_REG_CTRL, 32'h0, "ctrl");
    rd(`ACQ_REG_FCOUNT, 32'h1, "fcount");
    rd(`ACQ_REG_PERIOD, 32'h100, "period");
    rd(4'h7, 32'h0, "unmapped");
    per = 3 + $urandom % 4;
    wr(`ACQ_REG_PERIOD, per);
    wr(`ACQ_REG_FRAMELEN, 32'h3);
    n0 = nfr;
    idle(40);
    chk("nostart", n0, nfr);
    $display("test 1 done");
    wr(`ACQ_REG_CMD, 32'h1);
    chk("armed", 32'h2, acq_status_o);
    idle(60);
    chk("single", n0 + 1, nfr);
    chk("lapse", 32'h0, acq_status_o);
    $display("test 2 done");
    wr(`ACQ_REG_CTRL, 32'h2);
    wr(`ACQ_REG_CMD, 32'h1);
    idle(60);
    chk("cont", 32'h1, (nfr - n0) >= 4);
    repeat (200) if (frame_start_o !== 1'b1) @(posedge clock_i);
    wr(`ACQ_REG_CMD, 32'h2);
    chk("stopping", 32'h4, acq_status_o);
    chk("busy", 32'h1, frame_active_o);
    idle(20);
    n0 = nfr;
    chk("stopped", 32'h0, acq_status_o);
    idle(40);
    chk("refuse", n0, nfr);
    $display("test 3 done");
    wr(`ACQ_REG_TRIG, 32'h19);
    rd(`ACQ_REG_TRIG, trig_view(1'b1, 1'b1, 1'b1), "trigview");
    wr(`ACQ_REG_CMD, 32'h1);
    pulse;
    pulse;
    idle(20);
    chk("extone", n0 + 1, nfr);
    pulse;
    idle(20);
    chk("exttwo", n0 + 2, nfr);
    wr(`ACQ_REG_CMD, 32'h2);
    pulse;
    idle(20);
    chk("noext", n0 + 2, nfr);
    $display("test 4 done");
    wr(`ACQ_REG_CTRL, 32'h3);
    wr(`ACQ_REG_TRIG, 32'h2);
    wr(`ACQ_REG_FCOUNT, 32'h2);
    wr(`ACQ_REG_CMD, 32'h1);
    chk("waitarm", 32'h1, acq_status_o);
    pulse;
    idle(20);
    chk("armquiet", n0 + 2, nfr);
    wr(`ACQ_REG_CMD, 32'h4);
    chk("armgo", 32'h2, acq_status_o);
    pulse;
    idle(20);
    pulse;
    idle(20);
    chk("budget", n0 + 4, nfr);
    chk("rearm", 32'h1, acq_status_o);
    rd(`ACQ_REG_STATUS, 32'h11, "status");
    $display("test 5 done");
    rst_i <= 1'b1;
    idle(2);
    rst_i <= 1'b0;
    rd(`ACQ_REG_CTRL, 32'h0, "rectrl");
    scheme_startup_i <= 1'b1;
    startup_load_i <= 1'b1;
    idle(2);
    startup_load_i <= 1'b0;
    rd(`ACQ_REG_CTRL, 32'h1, "startup");
    $display("test 6 done");
    end_sim;
  end
endmodule // frame_acquisition_sequencer_tb_top
`default_nettype wire
